// [core/crossbar_switch_with_bridges.sv]
// crossbar switch: address decode, per-target arbitration, bridge stages, bridge control
`timescale 1ns/1ps
`default_nettype none
`include "xbar_cfg.svh"
module crossbar_switch_with_bridges #(
    parameter logic [4:0][2:0] PRIO_ORDER = `PRIO_ORDER_DEFAULT
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    // masters: 0 core data, 1 program fetch, 2 high dma, 3 low dma, 4 host
    input wire logic [4:0] m_req_i,
    input wire logic [4:0][31:0] m_addr_i,
    input wire logic [4:0] m_we_i,
    input wire logic [4:0][3:0] m_be_i,
    input wire logic [4:0][31:0] m_wdata_i,
    output logic [4:0] m_done_o,
    output logic [4:0][31:0] m_rdata_o,
    // targets: 0 on-chip, 1 ext memory, 2 periph bus, 3 audio dma bus, 4 dma regs
    output logic [4:0] t_req_o,
    output logic [4:0][31:0] t_addr_o,
    output logic [4:0] t_we_o,
    output logic [4:0][3:0] t_be_o,
    output logic [4:0][31:0] t_wdata_o,
    output logic [4:0][2:0] t_master_o,
    input wire logic [4:0] t_ack_i,
    input wire logic [4:0][31:0] t_rdata_i,
    output logic onchip_bridge_reset_o
);
    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic rst_meta_reg;
    logic rst_n_reg;

    // two flops so release is clean against clk
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg <= rst_meta_reg;
        end
    end

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    function automatic logic [23:0] periph_limit(input logic [3:0] win);
        case (win)
            4'h0: periph_limit = `LIM_DEVCFG;
            4'h1: periph_limit = `LIM_PLL;
            4'h2: periph_limit = `LIM_RTI;
            4'h3: periph_limit = `LIM_HOST;
            4'h4, 4'h5, 4'h6: periph_limit = `LIM_AUDIO;
            default: periph_limit = `LIM_SERIAL;
        endcase
    endfunction

    function automatic logic in_table(input logic [31:0] a, input logic [31:0] base);
        logic [15:0] off;
        off = a[15:0];
        in_table = (a[31:16] == base[31:16]) && (a[15] == 1'b1)
            && ((off[14:0] <= `TBL_EVENT_END)
            || ((off[14:0] >= `TBL_XFER_BASE) && (off[14:0] <= `TBL_XFER_END)));
    endfunction

    // word-only windows refuse partial byte enables and fall to the local answer
    function automatic xbar_pkg::tgt_t decode(input logic [31:0] a, input logic [3:0] be);
        logic word;
        word = (be == `BE_WORD);
        decode = xbar_pkg::TGT_NONE;
        if (((a >= `ROM_BASE) && (a <= `ROM_END)) || ((a >= `RAM_BASE) && (a <= `RAM_END))) begin
            decode = xbar_pkg::TGT_ONCHIP;
        end else if (a == `BRIDGE_CONTROL_ADDR) begin
            decode = word ? xbar_pkg::TGT_LOCAL : xbar_pkg::TGT_NONE;
        end else if ((a[31:28] == `PERIPH_NIBBLE) && (a[27:24] <= `PERIPH_LAST_WINDOW)
            && (a[23:0] <= periph_limit(a[27:24])) && word) begin
            decode = xbar_pkg::TGT_PERIPH;
        end else if ((a >= `AUDIO_BASE) && (a <= `AUDIO_END) && word) begin
            decode = xbar_pkg::TGT_AUDIO;
        end else if (((a >= `DMA_CTRL_BASE) && (a <= `DMA_CTRL_END) && word)
            || in_table(a, `DMA0_TBL_BASE) || in_table(a, `DMA1_TBL_BASE)) begin
            decode = xbar_pkg::TGT_DMAREG;
        end else if ((a >= `DRAM_BASE) && (a <= `ASYNC_END)) begin
            decode = xbar_pkg::TGT_EXTMEM;
        end else if ((a >= `EMC_BASE) && (a <= `EMC_END)
            && (word || ((a == `DRAM_CFG_ADDR) && (be == `BE_TOP_BYTE)))) begin
            decode = xbar_pkg::TGT_EXTMEM;
        end
    endfunction

    // ----------------------------------------------------------------
    // state and per-master routing
    // ----------------------------------------------------------------
    xbar_pkg::xbar_state_t s_reg;
    xbar_pkg::xbar_state_t s_next;
    xbar_pkg::tgt_t [4:0] dest;
    logic [4:0] live_req;
    logic [4:0][4:0] treq;
    logic [4:0] grant;
    logic [4:0][2:0] winner;
    logic [4:0][2:0] owner;
    logic [4:0] release_t;

    // done masks the request for one cycle so a finished access is not re-granted
    always_comb begin
        treq = '0;
        for (int m = 0; m < 5; m++) begin
            live_req[m] = m_req_i[m] & ~s_reg.m_done[m];
            dest[m] = decode(m_addr_i[m], m_be_i[m]);
            for (int t = 0; t < 5; t++) begin
                treq[t][m] = live_req[m] && (dest[m] == xbar_pkg::tgt_t'(t[2:0]));
            end
        end
        // no new on-chip grant while its bridge is held in reset
        if (s_reg.bridge_rst) begin
            treq[0] = '0;
        end
    end

    // an on-chip access caught by a bridge reset is aborted so its owner cannot hang
    always_comb begin
        for (int t = 0; t < 5; t++) begin
            release_t[t] = s_reg.t_req[t] & t_ack_i[t];
        end
        release_t[0] = s_reg.t_req[0] & (t_ack_i[0] | s_reg.bridge_rst);
    end

    // ----------------------------------------------------------------
    // one arbiter per target group
    // ----------------------------------------------------------------
    generate
        for (genvar g = 0; g < 5; g++) begin : g_arb
            target_arbiter #(
                .ORDER(PRIO_ORDER)
            ) u_arb (
                .clk_i(clk_i),
                .rst_n_i(rst_n_reg),
                .req_i(treq[g]),
                .release_i(release_t[g]),
                .grant_o(grant[g]),
                .winner_o(winner[g]),
                .owner_o(owner[g])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // next state: bridge stages, completions, local register
    // ----------------------------------------------------------------
    // each target stage is a one-deep bridge slot; one clock here, so no rate change
    always_comb begin
        s_next = s_reg;
        s_next.m_done = '0;
        for (int t = 0; t < 5; t++) begin
            if (release_t[t]) begin
                s_next.t_req[t] = 1'b0;
                s_next.m_done[owner[t]] = 1'b1;
                if (!s_reg.t_we[t] && t_ack_i[t] && !(t == 0 && s_reg.bridge_rst)) begin
                    s_next.m_rdata[owner[t]] = t_rdata_i[t];
                end else begin
                    s_next.m_rdata[owner[t]] = 32'h0000_0000;
                end
            end else if (grant[t]) begin
                // latch the winner's access into the bridge slot
                s_next.t_req[t] = 1'b1;
                s_next.t_addr[t] = m_addr_i[winner[t]];
                s_next.t_we[t] = m_we_i[winner[t]];
                s_next.t_be[t] = m_be_i[winner[t]];
                s_next.t_wdata[t] = m_wdata_i[winner[t]];
                s_next.t_master[t] = winner[t];
            end
        end
        // local answers; descending loop lets the lowest index win a write clash
        for (int m = 4; m >= 0; m--) begin
            if (live_req[m] && (dest[m] == xbar_pkg::TGT_NONE)) begin
                s_next.m_done[m] = 1'b1;
                s_next.m_rdata[m] = 32'h0000_0000;
            end else if (live_req[m] && (dest[m] == xbar_pkg::TGT_LOCAL)) begin
                s_next.m_done[m] = 1'b1;
                s_next.m_rdata[m] = {31'h0000_0000, s_reg.bridge_rst};
                if (m_we_i[m]) begin
                    s_next.bridge_rst = m_wdata_i[m][`BRIDGE_RST_BIT];
                end
            end
        end
        // aborted on-chip slot content is dropped with the bridge reset
        if (s_reg.bridge_rst) begin
            s_next.t_req[0] = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // state register and outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            s_reg <= '0;
            s_reg.bridge_rst <= `BRIDGE_CONTROL_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // all outputs are state bits straight from the register
    assign m_done_o = s_reg.m_done;
    assign m_rdata_o = s_reg.m_rdata;
    assign t_req_o = s_reg.t_req;
    assign t_addr_o = s_reg.t_addr;
    assign t_we_o = s_reg.t_we;
    assign t_be_o = s_reg.t_be;
    assign t_wdata_o = s_reg.t_wdata;
    assign t_master_o = s_reg.t_master;
    assign onchip_bridge_reset_o = s_reg.bridge_rst;
endmodule // crossbar_switch_with_bridges
`default_nettype wire

// [common/xbar_cfg.svh]
// address map, register layout, reset values and priority defaults of the crossbar switch
//
// Overview of operation
// - five masters each route an access to one of five target groups
// - different masters on different targets proceed together, no mutual stall
// - same-cycle contention grants highest priority master, others stall
// - an owner keeps its target until its access completes
// - high priority dma port beats low priority dma port on shared targets
// - program fetch port has fifth priority at external memory
// - every cross-rate path passes a small bridge buffer stage
// - core data and fetch bridges run core clock toward target clocks
// - dma and host path into on-chip memory uses the on-chip bridge
// - shared external memory bridge carries core, host and dma accesses
// - bridge control bit0 holds on-chip bridge in reset, resets to one
// - bridge control bits 31:1 read zero, writes to them ignored
// - rom and ram ranges route to on-chip memory, byte and word
// - word-only peripheral windows route to peripheral register bus
// - any word address in audio dma windows reaches audio dma bus
// - dma control and entry tables route to dma engine register target
// - dram and async/flash spaces route to external memory, byte and word
// - external memory control word-only, dram config top byte byte-writable
`ifndef XBAR_CFG_SVH
`define XBAR_CFG_SVH

// ----------------------------------------------------------------
// device register
// ----------------------------------------------------------------
`define BRIDGE_CONTROL_ADDR 32'h4000_0024
`define BRIDGE_RST_BIT 0
`define BRIDGE_CONTROL_RESET 1'b1

// ----------------------------------------------------------------
// on-chip memory ranges
// ----------------------------------------------------------------
`define ROM_BASE 32'h0000_0000
`define ROM_END 32'h0005_FFFF
`define RAM_BASE 32'h1000_0000
`define RAM_END 32'h1003_FFFF

// ----------------------------------------------------------------
// peripheral windows: base is 0x4n00_0000, limit is the high offset end
// ----------------------------------------------------------------
`define PERIPH_NIBBLE 4'h4
`define PERIPH_LAST_WINDOW 4'hA
`define LIM_DEVCFG 24'h00_0083
`define LIM_PLL 24'h00_015F
`define LIM_RTI 24'h00_00A3
`define LIM_HOST 24'h00_0043
`define LIM_AUDIO 24'h00_02BF
`define LIM_SERIAL 24'h00_007F

// ----------------------------------------------------------------
// audio dma, dma engine and external memory
// ----------------------------------------------------------------
`define AUDIO_BASE 32'h5400_0000
`define AUDIO_END 32'h56FF_FFFF
`define DMA_CTRL_BASE 32'h6000_0000
`define DMA_CTRL_END 32'h6000_008F
`define DMA0_TBL_BASE 32'h6100_8000
`define DMA1_TBL_BASE 32'h6200_8000
`define TBL_EVENT_END 16'h007F
`define TBL_XFER_BASE 16'h00A0
`define TBL_XFER_END 16'h01FF
`define DRAM_BASE 32'h8000_0000
`define ASYNC_END 32'h9FFF_FFFF
`define EMC_BASE 32'hF000_0000
`define EMC_END 32'hF000_00BF
`define DRAM_CFG_ADDR 32'hF000_0008
`define BE_WORD 4'hF
`define BE_TOP_BYTE 4'h8

// ----------------------------------------------------------------
// priority: master indices, lowest first; slot 0, written last, is highest
// ----------------------------------------------------------------
`define PRIO_ORDER_DEFAULT {3'h1, 3'h4, 3'h3, 3'h2, 3'h0}

`endif

// [common/xbar_pkg.sv]
// types shared by the crossbar switch and its target arbiters
`default_nettype none
package xbar_pkg;

    // target groups plus the two locally answered kinds
    typedef enum logic [2:0] {
        TGT_ONCHIP = 3'b000,
        TGT_EXTMEM = 3'b001,
        TGT_PERIPH = 3'b010,
        TGT_AUDIO = 3'b011,
        TGT_DMAREG = 3'b100,
        TGT_LOCAL = 3'b101,
        TGT_NONE = 3'b110
    } tgt_t;

    typedef enum logic [0:0] {
        ARB_IDLE = 1'b0,
        ARB_OWNED = 1'b1
    } arb_mode_t;

    typedef struct packed {
        arb_mode_t mode;
        logic [2:0] owner;
    } arb_state_t;

    typedef struct packed {
        logic bridge_rst;
        logic [4:0] m_done;
        logic [4:0][31:0] m_rdata;
        logic [4:0] t_req;
        logic [4:0][31:0] t_addr;
        logic [4:0] t_we;
        logic [4:0][3:0] t_be;
        logic [4:0][31:0] t_wdata;
        logic [4:0][2:0] t_master;
    } xbar_state_t;

endpackage
`default_nettype wire

// [core/target_arbiter.sv]
// fixed-priority arbiter that locks one target to its owner until release
`timescale 1ns/1ps
`default_nettype none
`include "xbar_cfg.svh"
module target_arbiter #(
    parameter logic [4:0][2:0] ORDER = `PRIO_ORDER_DEFAULT
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [4:0] req_i,
    input wire logic release_i,
    output logic grant_o,
    output logic [2:0] winner_o,
    output logic [2:0] owner_o
);
    xbar_pkg::arb_state_t s_reg;
    xbar_pkg::arb_state_t s_next;

    // later loop steps are higher priority, so slot 0 wins last
    always_comb begin
        winner_o = 3'h0;
        for (int i = 4; i >= 0; i--) begin
            if (req_i[ORDER[i]]) begin
                winner_o = ORDER[i];
            end
        end
        grant_o = (s_reg.mode == xbar_pkg::ARB_IDLE) && (|req_i);
        owner_o = s_reg.owner;
    end

    // ownership held until release, no re-arbitration mid access
    always_comb begin
        s_next = s_reg;
        case (s_reg.mode)
            xbar_pkg::ARB_IDLE: begin
                if (|req_i) begin
                    s_next.mode = xbar_pkg::ARB_OWNED;
                    s_next.owner = winner_o;
                end
            end
            xbar_pkg::ARB_OWNED: begin
                if (release_i) begin
                    s_next.mode = xbar_pkg::ARB_IDLE;
                end
            end
            default: begin
                s_next.mode = xbar_pkg::ARB_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_reg <= '{mode: xbar_pkg::ARB_IDLE, owner: 3'h0};
        end else begin
            s_reg <= s_next;
        end
    end
endmodule // target_arbiter
`default_nettype wire

// [verif/target_model.sv]
// behavioural targets answering the five crossbar target ports
`timescale 1ns/1ps
`default_nettype none
module target_model (
    input wire logic clk_i,
    input wire logic [4:0] t_req_i,
    input wire logic [4:0][31:0] t_addr_i,
    input wire logic [3:0] wait_i,
    output logic [4:0] t_ack_o,
    output logic [4:0][31:0] t_rdata_o
);
    logic [4:0][3:0] cnt_reg;
    // wait states counted while a request stands
    always_ff @(posedge clk_i) begin
        for (int t = 0; t < 5; t++) begin
            cnt_reg[t] <= t_req_i[t] ? cnt_reg[t] + 4'h1 : 4'h0;
        end
    end
    // data marks the target; inverted when not acking so stale data never matches
    always_comb begin
        for (int t = 0; t < 5; t++) begin
            t_ack_o[t] = t_req_i[t] && (cnt_reg[t] == wait_i);
            t_rdata_o[t] = t_addr_i[t] ^ {t[2:0], 29'h0};
            if (!t_ack_o[t]) t_rdata_o[t] = ~t_rdata_o[t];
        end
    end
endmodule // target_model
`default_nettype wire

// [verif/xbar_asserts.sv]
// concurrent checks on the crossbar switch ports
`timescale 1ns/1ps
`default_nettype none
module xbar_asserts (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [4:0] m_req_i,
    input wire logic [4:0] m_done_o,
    input wire logic [4:0] t_req_o,
    input wire logic [4:0][31:0] t_addr_o,
    input wire logic [4:0][3:0] t_be_o,
    input wire logic [4:0][2:0] t_master_o,
    input wire logic [4:0] t_ack_i,
    input wire logic onchip_bridge_reset_o
);
    default clocking dc @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // per target: completion reaches the owner, ownership frozen until answered or, for the on-chip target, until a bridge reset aborts it
    for (genvar t = 0; t < 5; t++) begin : g_t
        a_done_after_ack: assert property (
            t_req_o[t] && t_ack_i[t] |=> m_done_o[$past(t_master_o[t])]) else $error("no done after ack");
        a_owner_held: assert property (
            t_req_o[t] && !t_ack_i[t] && (t > 0 || !onchip_bridge_reset_o)
            |=> t_req_o[t] && $stable(t_master_o[t]) && $stable(t_addr_o[t])) else $error("owner changed");
    end
    // decode: each target only sees its own windows
    a_onchip_range: assert property (t_req_o[0] |-> t_addr_o[0] <= 32'h0005_FFFF ||
        (t_addr_o[0] >= 32'h1000_0000 && t_addr_o[0] <= 32'h1003_FFFF)) else $error("bad on-chip address");
    a_extmem_range: assert property (t_req_o[1] |-> t_addr_o[1] inside {[32'h8000_0000:32'h9FFF_FFFF]} ||
        (t_addr_o[1] inside {[32'hF000_0000:32'hF000_00BF]} &&
        (t_be_o[1] == 4'hF || (t_addr_o[1] == 32'hF000_0008 && t_be_o[1] == 4'h8)))) else $error("bad ext access");
    a_periph_word: assert property (t_req_o[2] |-> t_be_o[2] == 4'hF && t_addr_o[2][31:28] == 4'h4)
        else $error("bad periph access");
    a_audio_word: assert property (t_req_o[3] |-> t_be_o[3] == 4'hF &&
        t_addr_o[3] inside {[32'h5400_0000:32'h56FF_FFFF]}) else $error("bad audio access");
    a_dmareg_range: assert property (t_req_o[4] |-> t_addr_o[4][31:28] == 4'h6) else $error("bad dma access");
    a_bridge_gate: assert property (onchip_bridge_reset_o |=> !t_req_o[0]) else $error("on-chip in reset");
    a_done_single: assert property (|m_done_o |=> !(|(m_done_o & $past(m_done_o))))
        else $error("done longer than a cycle");
    // main scenarios
    c_parallel: cover property (t_req_o[1] && t_req_o[2] && t_req_o[3]);
    c_contend: cover property (t_req_o[2] && t_master_o[2] == 3'h2 && m_req_i[3]);
    c_gated: cover property (onchip_bridge_reset_o && m_req_i[4]);
endmodule // xbar_asserts
bind crossbar_switch_with_bridges xbar_asserts xbar_asserts_i (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .m_req_i(m_req_i), .m_done_o(m_done_o), .t_req_o(t_req_o), .t_addr_o(t_addr_o), .t_be_o(t_be_o),
    .t_master_o(t_master_o), .t_ack_i(t_ack_i), .onchip_bridge_reset_o(onchip_bridge_reset_o));
`default_nettype wire

// [verif/testbench.sv]
// self-checking bench: crossbar switch against behavioural targets
`timescale 1ns/1ps
`default_nettype none
`define CHECK(g, e) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("mismatch at %0t got %0h expected %0h", $time, (g), (e)); end end
module testbench;
    logic clk_i, rst_b_i, onchip_bridge_reset_o;
    logic [4:0] m_req_i, m_we_i, m_done_o, t_req_o, t_we_o, t_ack_i;
    logic [4:0][31:0] m_addr_i, m_wdata_i, m_rdata_o, t_addr_o, t_wdata_o, t_rdata_i;
    logic [4:0][3:0] m_be_i, t_be_o;
    logic [4:0][2:0] t_master_o;
    logic [3:0] wait_cycles;
    logic last_we;
    logic [3:0] last_be;
    logic [31:0] last_wdata;
    logic [31:0] r [5];
    int mismatches = 0, total_checks = 0, cycle = 0, fin [5];
    localparam logic [31:0] BRG = 32'h4000_0024;
    // unmapped probes stay in reserved space or in the table gap between event and transfer entries, never in emulation space
    logic [31:0] addrs [19] = '{32'h0, 32'h0005_FFFC, 32'h1003_FFFC, 32'h4000_0000, 32'h4A00_007C,
        32'h5400_0000, 32'h56FF_FFFC, 32'h6000_008C, 32'h6100_8000, 32'h6200_81FC, 32'h8000_0000,
        32'h9FFF_FFFC, 32'hF000_00BC, 32'h2000_0000, 32'h2000_001C, 32'h6100_809C, 32'h6200_8080,
        32'h6100_8080, 32'h6200_809C};
    int tgts [19] = '{0, 0, 0, 2, 2, 3, 3, 4, 4, 4, 1, 1, 1, 7, 7, 7, 7, 7, 7};

    crossbar_switch_with_bridges crossbar_switch_with_bridges_i (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .m_req_i(m_req_i), .m_addr_i(m_addr_i), .m_we_i(m_we_i), .m_be_i(m_be_i), .m_wdata_i(m_wdata_i),
        .m_done_o(m_done_o), .m_rdata_o(m_rdata_o), .t_req_o(t_req_o), .t_addr_o(t_addr_o), .t_we_o(t_we_o),
        .t_be_o(t_be_o), .t_wdata_o(t_wdata_o), .t_master_o(t_master_o), .t_ack_i(t_ack_i),
        .t_rdata_i(t_rdata_i), .onchip_bridge_reset_o(onchip_bridge_reset_o));
    target_model target_model_i (.clk_i(clk_i), .t_req_i(t_req_o), .t_addr_i(t_addr_o), .wait_i(wait_cycles),
        .t_ack_o(t_ack_i), .t_rdata_o(t_rdata_i));

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) cycle++;

    // what the external memory target saw on its last answered access
    always @(posedge clk_i) begin
        if (t_req_o[1] && t_ack_i[1]) begin
            last_we <= t_we_o[1];
            last_be <= t_be_o[1];
            last_wdata <= t_wdata_o[1];
        end
    end

    // request held until done is seen, dropped at the next edge
    task automatic access(input int m, input logic [31:0] a, input logic we, input logic [3:0] be,
        input logic [31:0] d, output logic [31:0] rd);
        int n;
        @(posedge clk_i);
        m_req_i[m] <= 1'b1;
        m_addr_i[m] <= a;
        m_we_i[m] <= we;
        m_be_i[m] <= be;
        m_wdata_i[m] <= d;
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (m_done_o[m] !== 1'b1 && n < 200);
        if (n >= 200) mismatches++;
        rd = m_rdata_o[m];
        fin[m] = cycle;
        @(posedge clk_i);
        m_req_i[m] <= 1'b0;
    endtask
    // target index folded into the top address bits by the model
    function automatic logic [31:0] routed(logic [31:0] a, int t);
        return (t > 4) ? 32'h0 : a ^ {t[2:0], 29'h0};
    endfunction
    task automatic chk(input int m, input logic [31:0] a, input logic [3:0] be, input logic [31:0] e);
        logic [31:0] d;
        access(m, a, 1'b0, be, 32'h0, d);
        `CHECK(d, e)
    endtask
    task automatic wr(input logic [31:0] d);
        logic [31:0] x;
        access(0, BRG, 1'b1, 4'hF, d, x);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ----------------
    // tests
    // ----------------
    initial begin
        rst_b_i = 1'b0;
        m_req_i = '0;
        m_addr_i = '0;
        m_we_i = '0;
        m_be_i = '0;
        m_wdata_i = '0;
        wait_cycles = 4'h0;
        repeat (20) @(posedge clk_i);
        rst_b_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        `CHECK(onchip_bridge_reset_o, 1'b1)
        chk(0, BRG, 4'hF, 32'h1);
        wr(32'h0000_0001);
        chk(0, BRG, 4'hF, 32'h1);
        wr(32'h0000_0000);
        chk(0, BRG, 4'hF, 32'h0);
        `CHECK(onchip_bridge_reset_o, 1'b0)
        $display("test bridge_control done");
        for (int i = 0; i < 19; i++) chk(4, addrs[i], 4'hF, routed(addrs[i], tgts[i]));
        chk(4, 32'h1000_0001, 4'h2, routed(32'h1000_0001, 0));
        chk(4, 32'h4000_0000, 4'h1, 32'h0);
        chk(4, 32'hF000_0008, 4'h8, routed(32'hF000_0008, 1));
        chk(4, 32'hF000_0004, 4'h8, 32'h0);
        // a byte write must reach the target with its lane, data and direction intact
        access(2, 32'h8000_0012, 1'b1, 4'h4, 32'hA5A5_5A5A, r[2]);
        `CHECK({last_we, last_be, last_wdata}, {1'b1, 4'h4, 32'hA5A5_5A5A})
        `CHECK(r[2], 32'h0000_0000)
        $display("test decode done");
        wait_cycles <= 4'h2;
        fork
            access(2, 32'h4200_0000, 1'b0, 4'hF, 32'h0, r[2]);
            access(3, 32'h4700_0000, 1'b0, 4'hF, 32'h0, r[3]);
            access(0, 32'h8000_0004, 1'b0, 4'hF, 32'h0, r[0]);
            access(1, 32'h8000_0000, 1'b0, 4'hF, 32'h0, r[1]);
        join
        `CHECK(fin[2] < fin[3], 1'b1)
        `CHECK(r[3], routed(32'h4700_0000, 2))
        `CHECK(fin[0] < fin[1], 1'b1)
        wait_cycles <= 4'h6;
        fork
            access(3, 32'h4700_0000, 1'b0, 4'hF, 32'h0, r[3]);
            begin
                repeat (2) @(posedge clk_i);
                access(0, 32'h4800_0000, 1'b0, 4'hF, 32'h0, r[0]);
            end
        join
        `CHECK(fin[3] < fin[0], 1'b1)
        $display("test priority done");
        wait_cycles <= 4'h0;
        fork
            access(1, 32'h9000_0000, 1'b0, 4'hF, 32'h0, r[1]);
            access(2, 32'h5500_0000, 1'b0, 4'hF, 32'h0, r[2]);
            access(3, 32'h4900_0000, 1'b0, 4'hF, 32'h0, r[3]);
            access(4, 32'h1000_0000, 1'b0, 4'hF, 32'h0, r[4]);
        join
        for (int m = 2; m < 5; m++) `CHECK(fin[m], fin[1])
        `CHECK(r[1], routed(32'h9000_0000, 1))
        `CHECK(r[4], routed(32'h1000_0000, 0))
        $display("test parallel done");
        wr(32'h1);
        fin[4] = 0;
        fork
            access(4, 32'h1000_0010, 1'b0, 4'hF, 32'h0, r[4]);
            begin
                repeat (10) @(posedge clk_i);
                `CHECK(fin[4], 0)
                wr(32'h0);
            end
        join
        `CHECK(r[4], routed(32'h1000_0010, 0))
        $display("test bridge_reset done");
        end_of_test();
    end
    // hang guard well beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        end_of_test();
    end
endmodule // testbench
`default_nettype wire
